// file: hdl/vdr_params.svh
`ifndef VDR_PARAMS_SVH
`define VDR_PARAMS_SVH

// array geometry: 256 rows of 256 one-bit columns
`define VDR_ROW_W 8
`define VDR_ROWS 256
`define VDR_COLS 256
// shift register sections: 64 bits each, chosen by two column bits
`define VDR_SECT_W 6
`define VDR_CODE_MSB 7
`define VDR_CODE_LSB 6
// serial output buffer depth
`define VDR_FIFO_DEPTH 8
// reset values
`define VDR_STROBE_RST 1'b1
`define VDR_PTR_RST 8'h00
`define VDR_CODE_RST 2'h0
`define VDR_SECT_LOW 6'h00

`endif

// file: hdl/vdr_pkg.sv
package vdr_pkg;

`include "vdr_params.svh"

    // strobes, address and data pins of the random port
    typedef struct packed {
        logic ras_n;
        logic cas_n;
        logic write_n;
        logic transfer_or_output_gate_n;
        logic [`VDR_ROW_W-1:0] multiplexed_address_bus;
        logic din;
    } vdr_pins_t;

    // array sequencer states, one-hot
    typedef enum logic [2:0] {
        VDR_ST_IDLE = 3'b001,
        VDR_ST_ACC = 3'b010,
        VDR_ST_LOAD = 3'b100
    } vdr_state_t;

endpackage : vdr_pkg

// file: hdl/vdr_row_mem.sv
`timescale 1ns/1ps
// row-wide storage array, registered read data
module vdr_row_mem #(
    parameter int WIDTH = 256,
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    // clocking
    input wire logic core_clk_i,
    input wire logic clk_en_i,
    // access port
    input wire logic rd_en_i,
    input wire logic wr_en_i,
    input wire logic [AW-1:0] row_i,
    input wire logic [WIDTH-1:0] wdata_i,
    output logic [WIDTH-1:0] rdata_o
);
    // storage, no reset: contents are undefined at power-up
    logic [WIDTH-1:0] cells [DEPTH];

    // write port
    always_ff @(posedge core_clk_i) begin
        if (clk_en_i && wr_en_i) begin
            cells[row_i] <= wdata_i;
        end
    end

    // read port, one cycle latency
    always_ff @(posedge core_clk_i) begin
        if (clk_en_i && rd_en_i) begin
            rdata_o <= cells[row_i];
        end
    end
endmodule : vdr_row_mem

// file: hdl/vdr_fifo.sv
`timescale 1ns/1ps
// small synchronous fifo with valid/ready on both sides
module vdr_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    // clocking
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] slots [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW:0] count_r;
    logic push;
    logic pop;

    assign in_ready_o = (count_r != (PW+1)'(DEPTH));
    assign out_valid_o = (count_r != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = slots[rd_ptr_r];

    // storage writes
    always_ff @(posedge core_clk_i) begin
        if (clk_en_i && push) begin
            slots[wr_ptr_r] <= in_data_i;
        end
    end

    // pointers and occupancy
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else if (clk_en_i) begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == PW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == PW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule : vdr_fifo

// file: hdl/vdr_video_dram.sv
`timescale 1ns/1ps
// Operation
// - 64K one-bit cells, row then column address
// - 256-bit shift register, four 64-bit sections
// - column bits pick first section; 00, 01
// - code 10 two upper, 11 top only
// - each section leaves bit 0 first
// - code 00 gives all 256 bits
// - reload allowed after any section boundary
// - row strobe alone refreshes the row
// - array-to-register transfer refreshes the row
// - addresses and data in latched, output not
// - ports independent except during transfers
// - separate serial in and out paths
// - transfer gate doubles as output enable
// - early write keeps data output off
// - serial drive enable gates serial output
// - page mode: many columns per row
// - gate at row strobe picks cycle type
// - write low: register to array
// - shift on rising serial clock edge
module vdr_video_dram (
    // clock, reset, enable
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    // random port
    input wire vdr_pkg::vdr_pins_t pins_i,
    output logic data_o,
    output logic data_oe_n_o,
    // sequential port
    input wire logic shift_clk_i,
    input wire logic serial_input_i,
    input wire logic serial_drive_enable_n_i,
    output logic serial_output_o,
    output logic serial_oe_n_o,
    // buffered copy of the shifted-out stream
    output logic stream_valid_o,
    input wire logic stream_ready_i,
    output logic stream_bit_o
);
    import vdr_pkg::*;

    // array geometry as parameters local to this design
    localparam int ROWS = `VDR_ROWS;
    localparam int COLS = `VDR_COLS;
    localparam int AW = `VDR_ROW_W;

    // previous samples for edge detection
    logic ras_q_r;
    logic cas_q_r;
    logic wr_q_r;
    logic sclk_q_r;

    // strobe edges, inputs already synchronous to core_clk_i
    logic ras_fall;
    logic ras_rise;
    logic cas_fall;
    logic wr_fall;
    logic sclk_rise;

    // latched cycle information
    logic [AW-1:0] row_r; // row address from the row strobe
    logic [AW-1:0] col_r; // column address from the column strobe
    logic din_r; // latched random data in
    logic xfer_r; // current row cycle is a register transfer
    logic to_array_r; // transfer direction: register into array
    logic early_wr_r; // write select was low before the column strobe
    logic [1:0] code_r; // section code for the next load
    logic wr_pend_r; // access in flight must write back

    // sequencer
    vdr_state_t state_r;
    vdr_state_t state_nxt;

    // array port
    logic mem_rd;
    logic mem_wr;
    logic [COLS-1:0] mem_wdata;
    logic [COLS-1:0] mem_rdata;
    logic [COLS-1:0] merged;

    // random output
    logic q_r; // bit read from the array
    logic q_valid_r; // read data available for this column cycle

    // serial path
    logic [COLS-1:0] sreg_r; // the 256-bit shift register
    logic [AW-1:0] ptr_r; // position of the head bit
    logic serial_output_r; // head bit presented on the serial pin
    logic acc_go;
    logic shift_req;
    logic shift_go;
    logic fifo_ready;

    // edge detection on the sampled pins
    assign ras_fall = ras_q_r && !pins_i.ras_n;
    assign ras_rise = !ras_q_r && pins_i.ras_n;
    assign cas_fall = cas_q_r && !pins_i.cas_n;
    assign wr_fall = wr_q_r && !pins_i.write_n;
    assign sclk_rise = !sclk_q_r && shift_clk_i;

    // strobe history, idles at inactive high after reset; shift clock history resets low
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ras_q_r <= `VDR_STROBE_RST;
            cas_q_r <= `VDR_STROBE_RST;
            wr_q_r <= `VDR_STROBE_RST;
            sclk_q_r <= 1'b0;
        end else if (clk_en_i) begin
            ras_q_r <= pins_i.ras_n;
            cas_q_r <= pins_i.cas_n;
            wr_q_r <= pins_i.write_n;
            sclk_q_r <= shift_clk_i;
        end
    end

    // row strobe latches row, cycle type and direction
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            row_r <= '0;
            xfer_r <= 1'b0;
            to_array_r <= 1'b0;
        end else if (clk_en_i && ras_fall) begin
            row_r <= pins_i.multiplexed_address_bus;
            xfer_r <= !pins_i.transfer_or_output_gate_n;
            to_array_r <= !pins_i.write_n;
        end
    end

    // column strobe latches column, data and write timing
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            col_r <= '0;
            din_r <= 1'b0;
            early_wr_r <= 1'b0;
        end else if (clk_en_i) begin
            if (cas_fall && !pins_i.ras_n && !xfer_r) begin
                // each new column in the open row is a page access
                col_r <= pins_i.multiplexed_address_bus;
                din_r <= pins_i.din;
                early_wr_r <= !pins_i.write_n;
            end else if (wr_fall && !pins_i.cas_n && !early_wr_r) begin
                // delayed write: the write strobe catches the data
                din_r <= pins_i.din;
            end
        end
    end

    // section code only moves when a transfer cycle strobes a column;
    // otherwise the previous choice is kept for the next load
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            code_r <= `VDR_CODE_RST;
        end else if (clk_en_i && cas_fall && !pins_i.ras_n && xfer_r) begin
            code_r <= pins_i.multiplexed_address_bus[`VDR_CODE_MSB:`VDR_CODE_LSB];
        end
    end

    // random access start: column strobe, or delayed write strobe
    // while the column strobe is already low
    always_comb begin
        acc_go = 1'b0;
        if (!pins_i.ras_n && !xfer_r) begin
            if (cas_fall) begin
                acc_go = 1'b1;
            end else if (wr_fall && !pins_i.cas_n && !early_wr_r) begin
                acc_go = 1'b1;
            end
        end
    end

    // bit insertion for a write: the whole row is read and rewritten,
    // which also refreshes it as the real sense amplifiers would
    always_comb begin
        merged = mem_rdata;
        merged[col_r] = din_r;
    end

    // array port control and next state
    always_comb begin
        mem_rd = 1'b0;
        mem_wr = 1'b0;
        mem_wdata = sreg_r;
        state_nxt = state_r;
        case (state_r)
            VDR_ST_IDLE: begin
                if (ras_rise && xfer_r) begin
                    // transfer completes as the row strobe returns high
                    if (to_array_r) begin
                        mem_wr = 1'b1;
                    end else begin
                        mem_rd = 1'b1;
                        state_nxt = VDR_ST_LOAD;
                    end
                end else if (acc_go) begin
                    mem_rd = 1'b1;
                    state_nxt = VDR_ST_ACC;
                end
            end
            VDR_ST_ACC: begin
                if (wr_pend_r) begin
                    mem_wr = 1'b1;
                    mem_wdata = merged;
                end
                state_nxt = VDR_ST_IDLE;
            end
            VDR_ST_LOAD: begin
                state_nxt = VDR_ST_IDLE;
            end
            default: begin
                state_nxt = VDR_ST_IDLE;
            end
        endcase
    end

    // sequencer state
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state_r <= VDR_ST_IDLE;
        end else if (clk_en_i) begin
            state_r <= state_nxt;
        end
    end

    // a write is pending when write select is low at the start
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            wr_pend_r <= 1'b0;
        end else if (clk_en_i && state_r == VDR_ST_IDLE && acc_go) begin
            wr_pend_r <= !pins_i.write_n;
        end
    end

    // read data: captured from the row, valid until the column
    // strobe rises; an early write never makes it valid
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            q_r <= 1'b0;
            q_valid_r <= 1'b0;
        end else if (clk_en_i) begin
            if (pins_i.cas_n) begin
                q_valid_r <= 1'b0;
            end else if (state_r == VDR_ST_ACC) begin
                q_r <= mem_rdata[col_r];
                q_valid_r <= !early_wr_r;
            end
        end
    end

    // random data output is not held beyond its enables: it drops as
    // soon as the column strobe or the gate goes high
    assign data_o = q_r;
    assign data_oe_n_o = !(q_valid_r && !pins_i.cas_n && !xfer_r
        && !pins_i.transfer_or_output_gate_n && !early_wr_r);

    // array: row-wide storage keeps transfers to a single access
    vdr_row_mem #(
        .WIDTH(COLS),
        .DEPTH(ROWS),
        .AW(AW)
    ) u_array (
        .core_clk_i(core_clk_i),
        .clk_en_i(clk_en_i),
        .rd_en_i(mem_rd),
        .wr_en_i(mem_wr),
        .row_i(row_r),
        .wdata_i(mem_wdata),
        .rdata_o(mem_rdata)
    );

    // a refresh needs no logic here: every row strobe already opens the
    // row, and static storage cannot lose it; the 4 ms window is the
    // controller's duty

    // shifting is held off during the load cycle so the parallel copy
    // and a shift never touch the register together
    assign shift_req = sclk_rise && (state_r != VDR_ST_LOAD);
    // a full stream buffer stalls the shift; the edge is then lost,
    // which is the price of never dropping a buffered bit
    assign shift_go = shift_req && fifo_ready;

    // shift register, load and serial shifting
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            sreg_r <= '0;
            ptr_r <= `VDR_PTR_RST;
        end else if (clk_en_i) begin
            if (state_r == VDR_ST_LOAD) begin
                sreg_r <= mem_rdata;
                // head jumps to bit 0 of the chosen section
                ptr_r <= {code_r, `VDR_SECT_LOW};
            end else if (shift_go) begin
                // input enters where the output left: in and out at once
                sreg_r[ptr_r] <= serial_input_i;
                // pointer runs bit 0 to 63 then into the next section;
                // any boundary is a valid reload point
                ptr_r <= ptr_r + 1'b1;
            end
        end
    end

    // head bit on the serial pin, also valid right after a load
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            serial_output_r <= 1'b0;
        end else if (clk_en_i) begin
            if (state_r == VDR_ST_LOAD) begin
                serial_output_r <= mem_rdata[{code_r, `VDR_SECT_LOW}];
            end else if (shift_go) begin
                serial_output_r <= sreg_r[ptr_r + 1'b1];
            end
        end
    end

    // serial pin gated by its own enable, for multiplexed streams
    assign serial_output_o = serial_output_r;
    assign serial_oe_n_o = serial_drive_enable_n_i;

    // every bit that leaves the register is also queued here
    vdr_fifo #(
        .WIDTH(1),
        .DEPTH(`VDR_FIFO_DEPTH)
    ) u_stream (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .in_valid_i(shift_req),
        .in_ready_o(fifo_ready),
        .in_data_i(serial_output_r),
        .out_valid_o(stream_valid_o),
        .out_ready_i(stream_ready_i),
        .out_data_o(stream_bit_o)
    );
endmodule : vdr_video_dram

// file: dv/vdr_video_dram_sva.sv
`timescale 1ns/1ps
// pin-level watch on the random-port output and the serial stream
module vdr_video_dram_sva (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // random port
    input wire vdr_pkg::vdr_pins_t pins_i,
    input wire logic data_oe_n_o,
    // sequential port
    input wire logic shift_clk_i,
    input wire logic serial_drive_enable_n_i,
    input wire logic serial_output_o,
    input wire logic serial_oe_n_o,
    input wire logic stream_valid_o,
    input wire logic stream_ready_i,
    input wire logic stream_bit_o
);
    import vdr_pkg::*;
    // cycle type seen at the last row fall, high = random access
    logic rand_cyc_r;
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    // remember the gate level at each row fall
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rand_cyc_r <= 1'b1;
        end else if ($fell(pins_i.ras_n)) begin
            rand_cyc_r <= pins_i.transfer_or_output_gate_n;
        end
    end
    property p_oe_gate;
        !data_oe_n_o |-> !pins_i.cas_n && !pins_i.transfer_or_output_gate_n;
    endproperty
    a_oe_gate: assert property (p_oe_gate) else $error("q driven without cas and gate");
    property p_early_wr;
        $fell(pins_i.cas_n) && !pins_i.write_n |-> data_oe_n_o [*3];
    endproperty
    a_early_wr: assert property (p_early_wr) else $error("q driven in early write");
    property p_read_oe;
        $fell(pins_i.cas_n) && !pins_i.ras_n && pins_i.write_n && rand_cyc_r
            ##2 !pins_i.cas_n && !pins_i.transfer_or_output_gate_n |-> !data_oe_n_o;
    endproperty
    a_read_oe: assert property (p_read_oe) else $error("read data not driven");
    property p_xfer_quiet;
        !rand_cyc_r && !pins_i.ras_n |-> data_oe_n_o;
    endproperty
    a_xfer_quiet: assert property (p_xfer_quiet) else $error("q driven in transfer");
    property p_soe;
        serial_oe_n_o == serial_drive_enable_n_i;
    endproperty
    a_soe: assert property (p_soe) else $error("serial enable mismatch");
    property p_stream_rise;
        $rose(shift_clk_i) && !stream_valid_o && pins_i.ras_n |-> ##[1:2] stream_valid_o;
    endproperty
    a_stream_rise: assert property (p_stream_rise) else $error("shift edge not taken");
    property p_stream_hold;
        stream_valid_o && !stream_ready_i |=> stream_valid_o && $stable(stream_bit_o);
    endproperty
    a_stream_hold: assert property (p_stream_hold) else $error("stalled bit lost");
    property p_ser_indep;
        rand_cyc_r && !pins_i.ras_n && !$past(shift_clk_i) && !$past(shift_clk_i, 2)
            |-> $stable(serial_output_o);
    endproperty
    a_ser_indep: assert property (p_ser_indep) else $error("serial moved by random cycle");
endmodule : vdr_video_dram_sva

bind vdr_video_dram vdr_video_dram_sva u_sva (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .pins_i(pins_i),
    .data_oe_n_o(data_oe_n_o),
    .shift_clk_i(shift_clk_i),
    .serial_drive_enable_n_i(serial_drive_enable_n_i),
    .serial_output_o(serial_output_o),
    .serial_oe_n_o(serial_oe_n_o),
    .stream_valid_o(stream_valid_o),
    .stream_ready_i(stream_ready_i),
    .stream_bit_o(stream_bit_o)
);

// file: dv/vdr_ctrl_model.sv
`timescale 1ns/1ps
// display controller model driving strobes, address and data
module vdr_ctrl_model (
    // clock
    input wire logic core_clk_i,
    // pins toward the memory
    output vdr_pkg::vdr_pins_t pins_o
);
    import vdr_pkg::*;
    // strobes idle high from time zero
    initial pins_o = 13'h1E00;
    // row fall: gate picks cycle type, write picks direction
    task automatic open_row(input logic [7:0] row, input logic gate_n, input logic wr_n);
        @(negedge core_clk_i);
        pins_o.ras_n = 1'b0;
        pins_o.transfer_or_output_gate_n = gate_n;
        pins_o.write_n = wr_n;
        pins_o.multiplexed_address_bus = row;
        repeat (2) @(negedge core_clk_i);
    endtask : open_row
    // column fall; page mode repeats it under one open row
    task automatic col(input logic [7:0] c, input logic d, input logic gate_n);
        pins_o.cas_n = 1'b0;
        pins_o.multiplexed_address_bus = c;
        pins_o.din = d;
        pins_o.transfer_or_output_gate_n = gate_n;
        repeat (3) @(negedge core_clk_i);
    endtask : col
    // delayed write: write select falls while the column strobe is low
    task automatic late_write(input logic d);
        pins_o.din = d;
        pins_o.write_n = 1'b0;
        repeat (3) @(negedge core_clk_i);
        pins_o.write_n = 1'b1;
    endtask : late_write
    // column rise; released lines must not keep the old value
    task automatic col_end();
        pins_o.cas_n = 1'b1;
        pins_o.transfer_or_output_gate_n = 1'b1;
        pins_o.multiplexed_address_bus = ~pins_o.multiplexed_address_bus;
        pins_o.din = ~pins_o.din;
        repeat (3) @(negedge core_clk_i);
    endtask : col_end
    // row rise, long enough for a register load to land
    task automatic close_row();
        pins_o.ras_n = 1'b1;
        pins_o.write_n = 1'b1;
        pins_o.transfer_or_output_gate_n = 1'b1;
        pins_o.multiplexed_address_bus = ~pins_o.multiplexed_address_bus;
        repeat (4) @(negedge core_clk_i);
    endtask : close_row
    // row-strobe-only sweep of every row, column strobe left high
    task automatic refresh_all();
        for (int r = 0; r < 256; r++) begin
            open_row(8'(r), 1'b1, 1'b1);
            close_row();
        end
    endtask : refresh_all
    // transfer cycle, section code only when asked for
    task automatic transfer(input logic [7:0] row, input logic to_array,
        input logic set_code, input logic [1:0] code);
        open_row(row, 1'b0, ~to_array);
        if (set_code) begin
            col({code, 6'h00}, 1'b0, 1'b0);
            col_end();
        end
        close_row();
    endtask : transfer
endmodule : vdr_ctrl_model

// file: dv/vdr_video_dram_tb.sv
`timescale 1ns/1ps
// page fill, refresh, readback, every section code, serial in, write back
module vdr_video_dram_tb;
    import vdr_pkg::*;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic sclk = 1'b0, serial_input = 1'b0, soe_n = 1'b1, rdy = 1'b1;
    logic q, q_oe_n, serial_output, serial_output_oe_n, s_valid, s_bit;
    vdr_pins_t pins;
    logic [255:0] mem_a, mem_b, reg_exp; // expected rows and register
    logic [7:0] ptr, row_a;
    logic sq [$]; // bits expected from the stream buffer
    int seed = 12, err_total = 0, compares = 0, cycles = 0;
    always #25 core_clk_i = ~core_clk_i;
    vdr_ctrl_model ctl (.core_clk_i(core_clk_i), .pins_o(pins));
    vdr_video_dram DUT (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
        .pins_i(pins), .data_o(q), .data_oe_n_o(q_oe_n),
        .shift_clk_i(sclk), .serial_input_i(serial_input), .serial_drive_enable_n_i(soe_n),
        .serial_output_o(serial_output), .serial_oe_n_o(serial_output_oe_n),
        .stream_valid_o(s_valid), .stream_ready_i(rdy), .stream_bit_o(s_bit));
    task automatic check(input string what, input logic seen, input logic exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %b seen %b", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish
    // hang guard, well above the few thousand cycles needed
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end
    // every popped stream bit against the order it was shifted
    always @(posedge core_clk_i) begin
        if (!sys_rst_i && s_valid === 1'b1 && rdy) begin
            check("stream", s_bit, sq.pop_front());
        end
    end
    // page-mode reads with the gate as output enable; ends of the row first
    task automatic read_row(input logic [7:0] row, input logic [255:0] m);
        logic [7:0] c;
        ctl.open_row(row, 1'b1, 1'b1);
        for (int i = 0; i < 16; i++) begin
            c = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
            ctl.col(c, 1'b0, 1'b0);
            check("q", q, m[c]);
            check("qoe", q_oe_n, 1'b0);
            ctl.col_end();
            check("qoff", q_oe_n, 1'b1);
        end
        ctl.close_row();
    endtask : read_row
    // shift edges two cycles apart; a full buffer refuses the edge
    task automatic shift(input int n, input bit stall);
        logic b;
        for (int i = 0; i < n; i++) begin
            if (stall && i == 10) begin
                rdy = 1'b1; // drain before random stalls resume
                repeat (12) @(negedge core_clk_i);
            end
            check("serial_output", serial_output, reg_exp[ptr]);
            b = 1'($random(seed));
            rdy = (stall && i < 10) ? 1'b0 : (($random(seed) & 3) != 0);
            soe_n = 1'($random(seed));
            serial_input = b;
            sclk = 1'b1;
            if (sq.size() < 8) begin
                sq.push_back(reg_exp[ptr]);
                reg_exp[ptr] = b;
                ptr++;
            end
            @(negedge core_clk_i);
            sclk = 1'b0;
            check("soe", serial_output_oe_n, soe_n);
            @(negedge core_clk_i);
        end
    endtask : shift
    initial begin
        row_a = 8'($random(seed));
        repeat (16) @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        // early writes of a whole row in page mode, gate held low
        ctl.open_row(row_a, 1'b1, 1'b0);
        for (int c = 0; c < 256; c++) begin
            mem_a[c] = 1'($random(seed));
            ctl.col(8'(c), mem_a[c], 1'b0);
            check("wroe", q_oe_n, 1'b1);
            ctl.col_end();
        end
        ctl.close_row();
        ctl.refresh_all();
        // delayed write to column 0 after a read; output follows the read
        ctl.open_row(row_a, 1'b1, 1'b1);
        ctl.col(8'h00, 1'b0, 1'b0);
        mem_a[0] = ~mem_a[0];
        ctl.late_write(mem_a[0]);
        check("dwoe", q_oe_n, 1'b0);
        ctl.col_end();
        ctl.close_row();
        read_row(row_a, mem_a);
        // each code: start section and reload after 256, 192, 128, 64 shifts
        for (int k = 0; k < 4; k++) begin
            ctl.transfer(row_a, 1'b0, 1'b1, 2'(k));
            reg_exp = mem_a;
            ptr = 8'(64 * k);
            shift(64 * (4 - k), k == 0);
        end
        // full ring of serial input, then written back to another row
        ctl.transfer(row_a, 1'b0, 1'b1, 2'h0);
        reg_exp = mem_a;
        ptr = 8'h00;
        shift(256, 1'b0);
        ctl.transfer(row_a ^ 8'h80, 1'b1, 1'b0, 2'h0);
        mem_b = reg_exp;
        read_row(row_a ^ 8'h80, mem_b);
        // no column fall: last code still applies
        ctl.transfer(row_a ^ 8'h80, 1'b0, 1'b0, 2'h3);
        reg_exp = mem_b;
        ptr = 8'h00;
        shift(64, 1'b0);
        repeat (8) @(negedge core_clk_i);
        tally_and_finish();
    end
endmodule : vdr_video_dram_tb
